// [verilog/lfs_pkg.sv]
// Constants, types and timing figures shared by the LED and system-rail fault supervisor.
// Function
// - Close duty loop switch during dimming on.
// - Open duty loop switch during dimming off.
// - Force auxiliary switch on while dimming off.
// - Auxiliary duty spans zero to full conduction.
// - Inactive compensation nodes keep their value.
// - Dimming gate output follows dimming input.
// - Pass very short dimming pulses undistorted.
// - Capacitive mode discharges soft start, raises frequency.
// - Capacitive mode above threshold frequency latches off.
// - Rail over-voltage latches off with fault.
// - Rail short for 7 us latches off.
// - Open rail feedback when off, 512 cycles.
// - Open rail feedback when on, 512 cycles.
// - LED over or unbalanced voltage for 8 us.
// - LED over-voltage: gate low, rail regulated, fault.
// - LED voltage above 3 V latches off.
// - LED over-current 7 us: gate low, rail regulated.
// - Over-current fault shown after 270 us.
// - Over-current lasting further 270 us latches off.
// - LED feedback over-current by two thresholds.
// - LED feedback open for 1024 cycles faults.
// - LED fault keeps resonant drive and rail.
// - LED stage off when low, disabled, faulted.
// - Fault indicator high for any latch-off or LED fault, over-current after 270 us.
// - Exactly one frequency loop switch closed while running.
package lfs_pkg;
  localparam int CLK_PERIOD_PS       = 25000;
  localparam int SYS_SHORT_TIME_NS   = 7000;
  localparam int LED_OVP_TIME_NS     = 8000;
  localparam int LED_HARD_TIME_NS    = 7600;
  localparam int LED_OCP_TIME_NS     = 7000;
  localparam int LED_OCP_HOLD_NS     = 270000;
  localparam int IFB_OVER_LOW_NS     = 340000;
  localparam int IFB_OVER_HIGH_NS    = 6000;
  localparam int SYS_SHORT_CYC       = (SYS_SHORT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LED_OVP_CYC         = (LED_OVP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LED_HARD_CYC        = (LED_HARD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LED_OCP_CYC         = (LED_OCP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LED_OCP_HOLD_CYC_DEF = (LED_OCP_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IFB_OVER_LOW_CYC_DEF = (IFB_OVER_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int IFB_OVER_HIGH_CYC   = (IFB_OVER_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SYS_OPEN_SW_CYCLES  = 512;
  localparam int LED_OPEN_SW_CYCLES  = 1024;
  localparam int CNT_W               = 16;
  localparam int NUM_QUAL            = 11;
  localparam int Q_SYS_SHORT = 0;
  localparam int Q_LED_OVP   = 1;
  localparam int Q_LED_HARD  = 2;
  localparam int Q_LED_OCP   = 3;
  localparam int Q_OCP_FLAG  = 4;
  localparam int Q_OCP_LATCH = 5;
  localparam int Q_IFB_LOW   = 6;
  localparam int Q_IFB_HIGH  = 7;
  localparam int Q_OPEN_OFF  = 8;
  localparam int Q_OPEN_ON   = 9;
  localparam int Q_LED_OPEN  = 10;
  localparam logic [NUM_QUAL-1:0] QUAL_ON_SWITCH_TICK = 11'h700;
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h004;
  localparam logic [ADDR_W-1:0] CAUSE_ADDR  = 12'h008;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam int CAUSE_W         = 7;
  localparam int C_CAP_MODE      = 0;
  localparam int C_SYS_OVP       = 1;
  localparam int C_SYS_SHORT     = 2;
  localparam int C_OPEN_OFF      = 3;
  localparam int C_OPEN_ON       = 4;
  localparam int C_LED_HARD      = 5;
  localparam int C_LED_OCP       = 6;
  localparam int STAT_W          = 5;
  localparam int S_LATCHED       = 0;
  localparam int S_PWM_OFF       = 1;
  localparam int S_LED_FAULT     = 2;
  localparam int S_FAULT_IND     = 3;
  localparam int S_RUNNING       = 4;
  typedef enum logic [1:0] {SUP_DISABLED, SUP_RUNNING, SUP_LATCHED} lfs_sup_state_type;
endpackage

// [verilog/lfs_reg_if.sv]
// Interface carrying control and status between the supervisor core and its register file.
`timescale 1ns/1ps
interface lfs_reg_if;
  logic                        device_enable;
  logic [lfs_pkg::CAUSE_W-1:0] cause_set;
  logic [lfs_pkg::STAT_W-1:0]  status;
  modport regs (output device_enable, input cause_set, input status);
  modport core (input device_enable, output cause_set, output status);
endinterface

// [verilog/lfs_qual_timer.sv]
// Qualification counter that reports a condition held for a set number of ticks.
`timescale 1ns/1ps
module lfs_qual_timer (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     reset_i,
  // Condition, count tick and limit
  input  wire logic                     cond_i,
  input  wire logic                     tick_i,
  input  wire logic [lfs_pkg::CNT_W-1:0] limit_i,
  // Qualified condition
  output logic                          done_o
);
  import lfs_pkg::*;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             done_q;

  always_comb begin
    count_d = count_q;
    if (!cond_i) begin
      count_d = '0;
    end else if (tick_i && count_q != limit_i) begin
      count_d = count_q + 16'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_q <= '0;
      done_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      done_q  <= cond_i && (count_d == limit_i);
    end
  end

  assign done_o = done_q;
endmodule

// [verilog/lfs_apb_regs.sv]
// APB register file of the supervisor: control, live status and sticky latch causes.
`timescale 1ns/1ps
module lfs_apb_regs (
  // Clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      reset_i,
  // APB slave
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [lfs_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]               pwdata_i,
  output logic      [31:0]               prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // Core side
  lfs_reg_if.regs                        core_if
);
  import lfs_pkg::*;
  logic               enable_q;
  logic [CAUSE_W-1:0] cause_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic               setup;
  logic               wr_en;
  logic [31:0]        rd_mux;
  logic               mapped;

  assign setup = psel_i && !penable_i;
  assign wr_en = psel_i && penable_i && pready_q && pwrite_i;

  always_comb begin
    rd_mux = 32'h00000000;
    mapped = 1'b1;
    case (paddr_i)
      CTRL_ADDR:   rd_mux[CTRL_ENABLE_BIT] = enable_q;
      STATUS_ADDR: rd_mux[STAT_W-1:0] = core_if.status;
      CAUSE_ADDR:  rd_mux[CAUSE_W-1:0] = cause_q;
      default:     mapped = 1'b0;
    endcase
  end

  // Answer one cycle after setup, so each transfer has exactly one access cycle.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
      prdata_q  <= (setup && !pwrite_i) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      enable_q <= CTRL_ENABLE_RESET;
    end else if (wr_en && paddr_i == CTRL_ADDR) begin
      enable_q <= pwdata_i[CTRL_ENABLE_BIT];
    end
  end

  // A cause arriving with its write-one clear stays set.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cause_q <= '0;
    end else if (wr_en && paddr_i == CAUSE_ADDR) begin
      cause_q <= (cause_q & ~pwdata_i[CAUSE_W-1:0]) | core_if.cause_set;
    end else begin
      cause_q <= cause_q | core_if.cause_set;
    end
  end

  assign core_if.device_enable = enable_q;
  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;
endmodule

// [verilog/lfs_led_llc_fault_supervisor.sv]
// Top of the LED and system-rail fault supervisor: loop selection, protections and pin drive.
`timescale 1ns/1ps
module lfs_led_llc_fault_supervisor #(
  parameter int LED_OCP_HOLD_CYC = lfs_pkg::LED_OCP_HOLD_CYC_DEF,
  parameter int IFB_OVER_LOW_CYC = lfs_pkg::IFB_OVER_LOW_CYC_DEF
) (
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       reset_i,
  // APB slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [lfs_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // Dimming and stage control
  input  wire logic                       dimming_pwm_in_i,
  input  wire logic                       led_stage_enable_i,
  input  wire logic                       switch_tick_i,
  input  wire logic                       aux_duty_cmp_i,
  // Resonant stage comparators
  input  wire logic                       cap_mode_sense_i,
  input  wire logic                       cap_freq_above_thr_i,
  // System rail comparators
  input  wire logic                       sys_fb_over_i,
  input  wire logic                       sys_fb_half_low_i,
  input  wire logic                       sys_current_short_i,
  input  wire logic                       voltage_loop_comp_sat_i,
  input  wire logic                       duty_loop_comp_high_i,
  // LED stage comparators
  input  wire logic                       led_string_over_i,
  input  wire logic                       led_string_diff_i,
  input  wire logic                       led_string_hard_over_i,
  input  wire logic                       led_current_feedback_over_low_i,
  input  wire logic                       led_current_feedback_over_high_i,
  input  wire logic                       led_current_feedback_half_low_i,
  input  wire logic                       current_loop_comp_sat_i,
  // Sense and fault pin, input side
  input  wire logic                       led_current_sense_fault_i,
  // Sense and fault pin, output side
  output logic                            led_current_sense_fault_o,
  output logic                            led_current_sense_fault_oe_o,
  // Loop switches
  output logic                            current_loop_switch_o,
  output logic                            voltage_loop_switch_o,
  output logic                            duty_loop_switch_o,
  // Power stage drive
  output logic                            aux_switch_on_o,
  output logic                            dim_gate_out_o,
  output logic                            llc_gate_enable_o,
  output logic                            soft_start_discharge_o,
  output logic                            freq_boost_o
);
  import lfs_pkg::*;

  localparam logic [CNT_W-1:0] QUAL_LIMIT [NUM_QUAL] = '{
    CNT_W'(SYS_SHORT_CYC),
    CNT_W'(LED_OVP_CYC),
    CNT_W'(LED_HARD_CYC),
    CNT_W'(LED_OCP_CYC),
    CNT_W'(LED_OCP_HOLD_CYC),
    CNT_W'(LED_OCP_HOLD_CYC),
    CNT_W'(IFB_OVER_LOW_CYC),
    CNT_W'(IFB_OVER_HIGH_CYC),
    CNT_W'(SYS_OPEN_SW_CYCLES),
    CNT_W'(SYS_OPEN_SW_CYCLES),
    CNT_W'(LED_OPEN_SW_CYCLES)
  };

  lfs_reg_if reg_if ();

  lfs_sup_state_type  sup_q;
  lfs_sup_state_type  sup_d;
  logic               running;
  logic               pwm_off;
  logic               led_fault_q;
  logic               led_fault_d;
  logic               ocp_fault_q;
  logic               fault_ind;
  logic [NUM_QUAL-1:0] qual_cond;
  logic [NUM_QUAL-1:0] qual_done;
  logic [CAUSE_W-1:0] cause;
  logic               any_cause;
  logic               current_sw_q;
  logic               voltage_sw_q;
  logic               duty_sw_q;
  logic               aux_q;
  logic               dim_q;
  logic               llc_en_q;
  logic               ss_dis_q;
  logic               boost_q;
  logic               fault_pin_q;
  logic               fault_oe_q;
  logic [STAT_W-1:0]  status_q;
  logic [CAUSE_W-1:0] cause_q;

  lfs_apb_regs u_regs (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .psel_i    (psel_i),
    .penable_i (penable_i),
    .pwrite_i  (pwrite_i),
    .paddr_i   (paddr_i),
    .pwdata_i  (pwdata_i),
    .prdata_o  (prdata_o),
    .pready_o  (pready_o),
    .pslverr_o (pslverr_o),
    .core_if   (reg_if.regs)
  );

  assign running = (sup_q == SUP_RUNNING);

  // The LED stage counts as off for any of these reasons.
  assign pwm_off = !dimming_pwm_in_i || !led_stage_enable_i || led_fault_q || !running;

  // Conditions under qualification.
  always_comb begin
    qual_cond              = '0;
    qual_cond[Q_SYS_SHORT] = running && sys_current_short_i;
    qual_cond[Q_LED_OVP]   = running && (led_string_over_i || led_string_diff_i);
    qual_cond[Q_LED_HARD]  = running && led_string_hard_over_i;
    qual_cond[Q_LED_OCP]   = running && led_current_sense_fault_i;
    qual_cond[Q_OCP_FLAG]  = ocp_fault_q;
    qual_cond[Q_OCP_LATCH] = ocp_fault_q && led_current_sense_fault_i;
    qual_cond[Q_IFB_LOW]   = running && led_current_feedback_over_low_i;
    qual_cond[Q_IFB_HIGH]  = running && led_current_feedback_over_high_i;
    qual_cond[Q_OPEN_OFF]  = running && pwm_off && sys_fb_half_low_i && voltage_loop_comp_sat_i;
    qual_cond[Q_OPEN_ON]   = running && !pwm_off && sys_fb_half_low_i && duty_loop_comp_high_i;
    qual_cond[Q_LED_OPEN]  = running && led_current_feedback_half_low_i && current_loop_comp_sat_i;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_QUAL; gi++) begin : g_qual
      lfs_qual_timer u_timer (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .cond_i  (qual_cond[gi]),
        .tick_i  (QUAL_ON_SWITCH_TICK[gi] ? switch_tick_i : 1'b1),
        .limit_i (QUAL_LIMIT[gi]),
        .done_o  (qual_done[gi])
      );
    end
  endgenerate

  // Conditions that shut the converter down for good.
  always_comb begin
    cause              = '0;
    cause[C_CAP_MODE]  = running && cap_mode_sense_i && cap_freq_above_thr_i;
    cause[C_SYS_OVP]   = running && sys_fb_over_i;
    cause[C_SYS_SHORT] = qual_done[Q_SYS_SHORT];
    cause[C_OPEN_OFF]  = qual_done[Q_OPEN_OFF];
    cause[C_OPEN_ON]   = qual_done[Q_OPEN_ON];
    cause[C_LED_HARD]  = qual_done[Q_LED_HARD];
    cause[C_LED_OCP]   = qual_done[Q_OCP_LATCH];
  end

  assign any_cause = |cause;

  // Latch-off persists until the device is disabled; a cause beats a pending disable.
  always_comb begin
    sup_d = sup_q;
    case (sup_q)
      SUP_DISABLED: begin
        if (reg_if.device_enable) begin
          sup_d = SUP_RUNNING;
        end
      end
      SUP_RUNNING: begin
        if (any_cause) begin
          sup_d = SUP_LATCHED;
        end else if (!reg_if.device_enable) begin
          sup_d = SUP_DISABLED;
        end
      end
      SUP_LATCHED: begin
        if (!reg_if.device_enable) begin
          sup_d = SUP_DISABLED;
        end
      end
      default: sup_d = SUP_DISABLED;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sup_q <= SUP_DISABLED;
    end else begin
      sup_q <= sup_d;
    end
  end

  // Over-current fault stays until it has been reported and the sense has recovered.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ocp_fault_q <= 1'b0;
    end else begin
      ocp_fault_q <= running && (qual_done[Q_LED_OCP] ||
                     (ocp_fault_q && (led_current_sense_fault_i || !qual_done[Q_OCP_FLAG])));
    end
  end

  // Non-latched LED faults only turn the LED stage off.
  assign led_fault_d = qual_done[Q_LED_OVP] || ocp_fault_q || qual_done[Q_IFB_LOW] ||
                       qual_done[Q_IFB_HIGH] || qual_done[Q_LED_OPEN];

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      led_fault_q <= 1'b0;
    end else begin
      led_fault_q <= running && led_fault_d;
    end
  end

  // Over-current shows on the indicator only after the hold time.
  assign fault_ind = (sup_q == SUP_LATCHED) || any_cause || qual_done[Q_LED_OVP] || qual_done[Q_OCP_FLAG] ||
                     qual_done[Q_IFB_LOW] || qual_done[Q_IFB_HIGH] || qual_done[Q_LED_OPEN];

  // One frequency loop at a time; the open loops hold their nodes.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      current_sw_q <= 1'b0;
      voltage_sw_q <= 1'b0;
    end else begin
      current_sw_q <= running && !pwm_off;
      voltage_sw_q <= running && pwm_off;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      duty_sw_q <= 1'b0;
    end else begin
      duty_sw_q <= running && !pwm_off;
    end
  end

  // The comparator passes straight through, so any duty from none to full is possible.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      aux_q <= 1'b0;
    end else begin
      aux_q <= running && (pwm_off || aux_duty_cmp_i);
    end
  end

  // One register stage only, so a pulse of a few microseconds keeps its width.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dim_q <= 1'b0;
    end else begin
      dim_q <= !pwm_off;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      llc_en_q <= 1'b0;
    end else begin
      llc_en_q <= running;
    end
  end

  // Soft start is also held discharged while not running, so each start ramps up.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ss_dis_q <= 1'b1;
      boost_q  <= 1'b0;
    end else begin
      ss_dis_q <= !running || cap_mode_sense_i;
      boost_q  <= running && cap_mode_sense_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      fault_pin_q <= 1'b0;
      fault_oe_q  <= 1'b0;
    end else begin
      fault_pin_q <= fault_ind;
      fault_oe_q  <= fault_ind;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      status_q <= '0;
      cause_q  <= '0;
    end else begin
      status_q[S_LATCHED]   <= (sup_d == SUP_LATCHED);
      status_q[S_PWM_OFF]   <= pwm_off;
      status_q[S_LED_FAULT] <= led_fault_q;
      status_q[S_FAULT_IND] <= fault_ind;
      status_q[S_RUNNING]   <= running;
      cause_q               <= cause;
    end
  end

  assign reg_if.status    = status_q;
  assign reg_if.cause_set = cause_q;

  assign current_loop_switch_o        = current_sw_q;
  assign voltage_loop_switch_o        = voltage_sw_q;
  assign duty_loop_switch_o           = duty_sw_q;
  assign aux_switch_on_o              = aux_q;
  assign dim_gate_out_o               = dim_q;
  assign llc_gate_enable_o            = llc_en_q;
  assign soft_start_discharge_o       = ss_dis_q;
  assign freq_boost_o                 = boost_q;
  assign led_current_sense_fault_o    = fault_pin_q;
  assign led_current_sense_fault_oe_o = fault_oe_q;
endmodule

// [tb/lfs_props.sv]
// Checker of loop switching, dimming drive and latch-off at the supervisor pins.
`timescale 1ns/1ps
module lfs_props (
  // Clock, reset and bus select
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic psel_i,
  // Watched pins
  input wire logic dimming_pwm_in_i,
  input wire logic cap_mode_sense_i,
  input wire logic cap_freq_above_thr_i,
  input wire logic sys_fb_over_i,
  input wire logic sys_current_short_i,
  input wire logic led_current_sense_fault_o,
  input wire logic led_current_sense_fault_oe_o,
  input wire logic current_loop_switch_o,
  input wire logic voltage_loop_switch_o,
  input wire logic duty_loop_switch_o,
  input wire logic aux_switch_on_o,
  input wire logic dim_gate_out_o,
  input wire logic llc_gate_enable_o,
  input wire logic freq_boost_o
);
  import lfs_pkg::*;
  logic [9:0] run_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Saturates so that a long short never wraps back to a small count.
  always_ff @(posedge clock_i) begin
    if (reset_i || !sys_current_short_i) begin
      run_q <= 10'h000;
    end else if (run_q != 10'h3FF) begin
      run_q <= run_q + 10'h001;
    end
  end
  property p_one; !(current_loop_switch_o && voltage_loop_switch_o); endproperty
  a_one: assert property (p_one) else $error("both loops closed");
  property p_duty; duty_loop_switch_o |-> current_loop_switch_o && !voltage_loop_switch_o; endproperty
  a_duty: assert property (p_duty) else $error("duty loop closed while off");
  property p_aux; voltage_loop_switch_o |-> aux_switch_on_o; endproperty
  a_aux: assert property (p_aux) else $error("aux switch not forced on");
  property p_dim; !dimming_pwm_in_i [*3] |=> !dim_gate_out_o; endproperty
  a_dim: assert property (p_dim) else $error("dim gate high without input");
  property p_ovp;
    sys_fb_over_i && llc_gate_enable_o |-> ##[1:3] led_current_sense_fault_o && !llc_gate_enable_o;
  endproperty
  a_ovp: assert property (p_ovp) else $error("rail overvoltage not latched");
  property p_cap;
    cap_mode_sense_i && cap_freq_above_thr_i && llc_gate_enable_o |-> ##[1:3] !llc_gate_enable_o;
  endproperty
  a_cap: assert property (p_cap) else $error("capacitive mode not latched");
  property p_boost; cap_mode_sense_i && !cap_freq_above_thr_i && llc_gate_enable_o |=> freq_boost_o; endproperty
  a_boost: assert property (p_boost) else $error("no frequency boost");
  property p_short; run_q >= SYS_SHORT_CYC + 4 |-> !llc_gate_enable_o; endproperty
  a_short: assert property (p_short) else $error("rail short not latched");
  property p_pin; led_current_sense_fault_o == led_current_sense_fault_oe_o; endproperty
  a_pin: assert property (p_pin) else $error("fault pin drive mismatch");
  // Bus writes are excluded because only a disable write may end the latch.
  property p_hold;
    !llc_gate_enable_o && led_current_sense_fault_o && !psel_i && !$past(psel_i) && !$past(psel_i, 2)
      |=> !llc_gate_enable_o;
  endproperty
  a_hold: assert property (p_hold) else $error("latch cleared on its own");
endmodule
bind lfs_led_llc_fault_supervisor lfs_props u_props (.*);

// [tb/lfs_plant_model.sv]
// Far-side model: switching ticks, duty comparator and comparator fault levels.
`timescale 1ns/1ps
module lfs_plant_model (
  // Clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // Fault levels commanded by the bench
  input  wire logic [14:0] flt_i,
  // Comparator outputs
  output logic             tick_o,
  output logic             duty_o,
  output logic      [14:0] cmp_o
);
  logic [1:0] ph_q;
  // One switching cycle every four clocks keeps the 512-cycle counts short.
  always_ff @(posedge clock_i) begin
    ph_q   <= reset_i ? 2'h0 : ph_q + 2'h1;
    tick_o <= (ph_q == 2'h3);
    duty_o <= (ph_q != 2'h0);
    cmp_o  <= flt_i;
  end
endmodule

// [tb/lfs_led_llc_fault_supervisor_tb.sv]
// Self-checking bench for the LED and system-rail fault supervisor.
`timescale 1ns/1ps
module lfs_led_llc_fault_supervisor_tb;
  import lfs_pkg::*;
  logic        clock_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
  logic [11:0] paddr_i;
  logic [14:0] flt, cmp;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic        dimming_pwm_in_i, led_stage_enable_i, switch_tick_i, aux_duty_cmp_i, cap_mode_sense_i;
  logic        cap_freq_above_thr_i, sys_fb_over_i, sys_fb_half_low_i, sys_current_short_i;
  logic        voltage_loop_comp_sat_i, duty_loop_comp_high_i, led_string_over_i, led_string_diff_i;
  logic        led_string_hard_over_i, led_current_feedback_over_low_i, led_current_feedback_over_high_i;
  logic        led_current_feedback_half_low_i, current_loop_comp_sat_i, led_current_sense_fault_i;
  logic        led_current_sense_fault_o, led_current_sense_fault_oe_o, current_loop_switch_o;
  logic        voltage_loop_switch_o, duty_loop_switch_o, aux_switch_on_o, dim_gate_out_o;
  logic        llc_gate_enable_o, soft_start_discharge_o, freq_boost_o;
  int          fail_count, checked;
  logic [31:0] n;
  logic [15:0] lm [7] = '{16'h0001, 16'h0002, 16'h000C, 16'h0030, 16'h0400, 16'h0800, 16'hC010};
  int          lw [7] = '{8, 300, 8, 2200, 330, 340, 2200};
  int          lb [7] = '{C_SYS_OVP, C_SYS_SHORT, C_CAP_MODE, C_OPEN_OFF, C_LED_HARD, C_LED_OCP, C_OPEN_ON};
  logic [14:0] nm [5] = '{15'h0040, 15'h0080, 15'h0100, 15'h0200, 15'h3000};
  int          nw [5] = '{340, 340, 260, 80, 4200};
  assign {duty_loop_comp_high_i, led_current_feedback_half_low_i, current_loop_comp_sat_i,
          led_current_sense_fault_i, led_string_hard_over_i, led_current_feedback_over_low_i,
          led_current_feedback_over_high_i, led_string_diff_i, led_string_over_i, voltage_loop_comp_sat_i,
          sys_fb_half_low_i, cap_freq_above_thr_i, cap_mode_sense_i, sys_current_short_i, sys_fb_over_i} = cmp;
  lfs_led_llc_fault_supervisor #(.LED_OCP_HOLD_CYC(40), .IFB_OVER_LOW_CYC(60)) dut (.*);
  lfs_plant_model plant (.clock_i(clock_i), .reset_i(reset_i), .flt_i(flt), .tick_o(switch_tick_i),
                         .duty_o(aux_duty_cmp_i), .cmp_o(cmp));
  always #12.5 clock_i = ~clock_i;
  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task cyc(input int c);
    repeat (c) @(posedge clock_i);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
    @(posedge clock_i);
    penable_i <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      wrap_up();
    end
    rd = prdata_o;
    er = pslverr_o;
    {psel_i, penable_i} <= 2'h0;
  endtask
  initial begin
    {clock_i, reset_i, psel_i, penable_i, pwrite_i, dimming_pwm_in_i, led_stage_enable_i} = 7'h20;
    {paddr_i, pwdata_i, flt, fail_count, checked} = '0;
    cyc(12);
    reset_i <= 1'b0;
    cyc(3);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h00C, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      {dimming_pwm_in_i, led_stage_enable_i} <= i[1:0];
      cyc(6);
      chk({current_loop_switch_o, duty_loop_switch_o, voltage_loop_switch_o}, (i == 3) ? 3'h6 : 3'h1);
      chk({dim_gate_out_o, aux_switch_on_o || i == 3}, {i == 3, 1'b1});
    end
    dimming_pwm_in_i <= 1'b0;
    cyc(6);
    dimming_pwm_in_i <= 1'b1;
    cyc(1);
    dimming_pwm_in_i <= 1'b0;
    n = 0;
    repeat (8) begin
      @(posedge clock_i);
      n += dim_gate_out_o;
    end
    chk(n, 1);
    dimming_pwm_in_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      flt <= nm[i];
      cyc(nw[i]);
      chk({dim_gate_out_o, aux_switch_on_o, voltage_loop_switch_o}, 3'h3);
      chk({llc_gate_enable_o, led_current_sense_fault_o}, 2'h3);
      flt <= 15'h0000;
      cyc(10);
    end
    // The stage is already off here, but the indicator waits for the over-current hold time.
    flt <= 15'h0800;
    cyc(300);
    chk({dim_gate_out_o, aux_switch_on_o, led_current_sense_fault_o, llc_gate_enable_o}, 4'h5);
    dimming_pwm_in_i <= 1'b0;
    flt <= 15'h0002;
    cyc(250);
    flt <= 15'h0000;
    cyc(1);
    flt <= 15'h0002;
    cyc(250);
    chk(llc_gate_enable_o, 1);
    flt <= 15'h0004;
    cyc(6);
    chk({freq_boost_o, soft_start_discharge_o, llc_gate_enable_o}, 3'h7);
    for (int i = 0; i < 7; i++) begin
      {dimming_pwm_in_i, flt} <= lm[i];
      cyc(lw[i]);
      chk({llc_gate_enable_o, led_current_sense_fault_o}, 2'h1);
      flt <= 15'h0000;
      apb(1'b0, CAUSE_ADDR, 32'h0);
      chk(rd, 32'h1 << lb[i]);
      apb(1'b1, CAUSE_ADDR, 32'h1 << lb[i]);
      apb(1'b0, CAUSE_ADDR, 32'h0);
      chk({rd[30:0], llc_gate_enable_o}, 32'h0);
      apb(1'b1, CTRL_ADDR, 32'h0);
      apb(1'b1, CTRL_ADDR, 32'h1);
      cyc(4);
      chk(llc_gate_enable_o, 1);
    end
    wrap_up();
  end
endmodule
